// >>> core/ppc_pkg.sv
// Package for the port configuration register bank: address, field positions,
// reset values and the carrier types shared by the core and its helpers.
// Assumes a 5-bit management register address space and 16-bit register data.
//
// Summary of operation
// R1 - Bit 4 set: strict standard crossover algorithm.
// R2 - Bit 4 clear: longer first crossover switch timer.
// R3 - Bit 5 clear: receive valid rises with SFD.
// R4 - Bit 5 set: receive valid and preamble after CRS.
// R5 - Bit 7 enables or disables speed downgrade.
// R6 - Soft reset loads bit 7 from nonvolatile bit.
// R7 - Bit 8 set: no loopback in 10M half duplex.
// R8 - Bit 11 bypasses 4B5B coder at 100M.
// R9 - Bit 12 bypasses scrambler and descrambler at 100M.
// R10 - Bit 13 disables the twisted-pair transmitter.
// R11 - Force link at 10M drives link signals active.
// R12 - Force link at 100M enters link good state.
// R13 - Force link at gigabit only skips negotiation.
// R14 - Reserved top field reads zero, software writes zero.
// R15 - Software writes zero to reserved bits 6, 9.
// R16 - Other fields reset to zero and hold writes.

package ppc_pkg;

   // --------------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------------
   localparam logic [4:0] ADDR_PORT_CFG = 5'h10; // Port configuration register index.

   // Field positions inside the port configuration register.
   localparam int BIT_MDIX_STRICT = 4;
   localparam int BIT_PREAMBLE_PASS = 5;
   localparam int BIT_SPEED_DOWNGRADE = 7;
   localparam int BIT_LOOPBACK_SUPPRESS = 8;
   localparam int BIT_JABBER_DISABLE = 10;
   localparam int BIT_BYPASS_4B5B = 11;
   localparam int BIT_BYPASS_SCRAMBLE = 12;
   localparam int BIT_TX_DISABLE = 13;
   localparam int BIT_FORCE_LINK = 14;

   // Reset value: preamble pass and loopback suppression set, all else clear.
   localparam logic [15:0] PORT_CFG_RESET = 16'h0120;
   // Bits that software may change; bit 15 and the low nibble read as zero.
   localparam logic [15:0] PORT_CFG_WMASK = 16'h7FF0;

   // Speed encodings of the resolved line speed.
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;

   // Crossover timer defaults, in clock cycles.
   localparam int MDIX_STD_CYCLES = 63;
   localparam int MDIX_LONG_CYCLES = 127;

   // --------------------------------------------------------------------
   // Carriers
   // --------------------------------------------------------------------
   // Link state presented to the link indication helper.
   typedef struct packed {
      logic [1:0] speed; // Resolved line speed.
      logic force_link; // Force link pass control.
      logic line_link; // True link state seen on the line.
   } ppc_link_in_t;

   // Link indications produced by the helper.
   typedef struct packed {
      logic link_ind; // Link indication signal.
      logic link_good_state; // Link monitor sits in its good state.
      logic an_skip; // Auto-negotiation is bypassed.
   } ppc_link_out_t;

endpackage

// >>> core/ppc_link_force.sv
// Link indication helper: applies the force link pass control per speed.
// Assumes the resolved speed and true line link are synchronous to the clock.

`timescale 1ns/1ps
`default_nettype none

module ppc_link_force
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire ppc_pkg::ppc_link_in_t i_link,
   output ppc_pkg::ppc_link_out_t o_link
);

   // All state of this helper is the registered link output.
   ppc_pkg::ppc_link_out_t state;
   ppc_pkg::ppc_link_out_t next_state;

   // --------------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------------
   // Only the gigabit case keeps the true line state on the link indication when forced.
   always_comb
   begin
      next_state = state;
      case (i_link.speed)
         ppc_pkg::SPEED_10:
         begin
            next_state.link_ind = i_link.force_link | i_link.line_link; // see R11
            next_state.link_good_state = i_link.line_link;
            next_state.an_skip = 1'b0;
         end
         ppc_pkg::SPEED_100:
         begin
            next_state.link_good_state = i_link.force_link | i_link.line_link; // see R12
            next_state.link_ind = i_link.force_link | i_link.line_link;
            next_state.an_skip = 1'b0;
         end
         default:
         begin
            next_state.link_ind = i_link.line_link; // see R13
            next_state.link_good_state = i_link.line_link;
            next_state.an_skip = i_link.force_link; // see R13
         end
      endcase
   end

   // Register the whole state.
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
         state <= '0;
      else
         state <= next_state;
   end

   assign o_link = state;

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   AST_LINK_10M: assert property (@(posedge i_clock) disable iff (!i_arst_n) // see R11
      (i_link.speed == ppc_pkg::SPEED_10 && i_link.force_link) |=> o_link.link_ind)
      else $error("Forced 10M link not indicated.");
   AST_LINK_100M: assert property (@(posedge i_clock) disable iff (!i_arst_n) // see R12
      (i_link.speed == ppc_pkg::SPEED_100 && i_link.force_link) |=> o_link.link_good_state)
      else $error("Forced 100M link monitor not good.");
   AST_LINK_1G: assert property (@(posedge i_clock) disable iff (!i_arst_n) // see R13
      (i_link.speed == ppc_pkg::SPEED_1000) |=>
      (o_link.link_ind == $past(i_link.line_link) && o_link.an_skip == $past(i_link.force_link)))
      else $error("Gigabit link not reported truly.");

endmodule

`default_nettype wire

// >>> core/ppc_mdix_timer.sv
// Crossover switch timer: swaps pairs each time the timer runs out with no link.
// Assumes the link input is synchronous; the strict input selects timer lengths.

`timescale 1ns/1ps
`default_nettype none

module ppc_mdix_timer
#(
   parameter int STD_CYCLES = ppc_pkg::MDIX_STD_CYCLES,
   parameter int LONG_CYCLES = ppc_pkg::MDIX_LONG_CYCLES,
   parameter int CW = 12
)
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_strict,
   input wire logic i_link_up,
   output logic o_swap
);

   // One-hot phase: the first timeout may be long, later ones are standard.
   typedef enum logic [1:0] {TM_FIRST = 2'b01, TM_NEXT = 2'b10} ppc_tm_t;

   // Whole state of the timer.
   typedef struct packed {
      ppc_tm_t phase;
      logic [CW-1:0] count;
      logic swap;
   } ppc_timer_t;

   ppc_timer_t state;
   ppc_timer_t next_state;
   logic [CW-1:0] limit; // Timeout for the current phase.

   // --------------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------------
   // A longer first wait lets a forced-speed side meet a negotiating partner.
   always_comb
   begin
      next_state = state;
      if (state.phase == TM_FIRST && !i_strict)
         limit = CW'(LONG_CYCLES); // see R2
      else
         limit = CW'(STD_CYCLES); // see R1
      if (i_link_up)
      begin
         next_state.phase = TM_FIRST;
         next_state.count = '0;
      end
      else if (state.count >= limit)
      begin
         next_state.count = '0;
         next_state.swap = ~state.swap;
         case (state.phase)
            TM_FIRST: next_state.phase = TM_NEXT;
            TM_NEXT: next_state.phase = TM_NEXT;
            default: next_state.phase = TM_FIRST;
         endcase
      end
      else
         next_state.count = state.count + CW'(1);
   end

   // Register the whole state.
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state.phase <= TM_FIRST;
         state.count <= '0;
         state.swap <= 1'b0;
      end
      else
         state <= next_state;
   end

   assign o_swap = state.swap;

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   AST_MDIX_STRICT: assert property (@(posedge i_clock) disable iff (!i_arst_n) // see R1
      (i_strict && !i_link_up && state.count == CW'(STD_CYCLES)) |=> (o_swap != $past(o_swap)))
      else $error("Strict timer did not swap at standard timeout.");
   AST_MDIX_LONG: assert property (@(posedge i_clock) disable iff (!i_arst_n) // see R2
      (!i_strict && state.phase == TM_FIRST && !i_link_up && state.count == CW'(STD_CYCLES))
      |=> (o_swap == $past(o_swap)))
      else $error("First timeout was not lengthened.");

endmodule

`default_nettype wire

// >>> core/ppc_port_cfg.sv
// Port configuration register bank of the copper transceiver and the logic it steers.
// Assumes a plain register port: strobes are one cycle, never both at once,
// read data stand in the cycle after the read strobe. All inputs are synchronous.
//
// Decided for this implementation: the strobed register port and the address map.

`timescale 1ns/1ps
`default_nettype none

module ppc_port_cfg
#(
   parameter int MDIX_STD_CYCLES = ppc_pkg::MDIX_STD_CYCLES,
   parameter int MDIX_LONG_CYCLES = ppc_pkg::MDIX_LONG_CYCLES
)
(
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   input wire logic I_SW_RESET,
   input wire logic I_SPEED_DOWNGRADE_DEFAULT_BIT,
   input wire logic [4:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WE,
   input wire logic I_RE,
   input wire logic [1:0] I_SPEED,
   input wire logic I_FULL_DUPLEX,
   input wire logic I_LINE_LINK,
   input wire logic I_CRS,
   input wire logic I_SFD,
   output logic [15:0] O_RDATA,
   output logic O_RX_DV,
   output logic O_RX_PREAMBLE,
   output logic O_SPEED_DOWNGRADE_EN,
   output logic O_TP_LOOPBACK_SUPPRESS,
   output logic O_JABBER_DISABLE,
   output logic O_BYPASS_4B5B,
   output logic O_BYPASS_SCRAMBLER,
   output logic O_TX_DISABLE,
   output logic O_MDIX_SWAP,
   output logic O_LINK_IND,
   output logic O_LINK_GOOD_STATE,
   output logic O_AN_SKIP
);

   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   // Every flip-flop of the core lives in this one struct.
   // The steered controls are registers, not decodes of the stored value,
   // so every output leaves a flip-flop. The cost is one cycle of latency
   // between the register and the hardware it steers. Software never sees
   // it, because the steered controls cannot be read back.
   typedef struct packed {
      logic [15:0] port_configuration_register; // Stored register value.
      logic [15:0] rdata; // Read data, valid the cycle after a read.
      logic rx_dv; // Receive data valid toward the MAC.
      logic rx_preamble; // Receive data carry preamble, not frame data.
      logic speed_downgrade_en; // Automatic speed downgrade enable.
      logic loopback_suppress; // No twisted-pair loopback now.
      logic jabber_disable; // Jabber function disabled.
      logic bypass_4b5b; // 4B5B coder bypass in effect.
      logic bypass_scrambler; // Scrambler bypass in effect.
      logic tx_disable; // Transmitter off.
   } ppc_core_t;

   ppc_core_t state;
   ppc_core_t next_state;

   logic [15:0] cfg; // Short alias of the stored register.
   logic is_100; // Line runs at 100M.
   logic hit; // The address selects the port configuration register.
   ppc_pkg::ppc_link_in_t link_in; // Link facts for the link helper.
   ppc_pkg::ppc_link_out_t link_out; // Link indications from the helper.

   assign cfg = state.port_configuration_register;
   assign is_100 = (I_SPEED == ppc_pkg::SPEED_100);
   assign hit = (I_ADDR == ppc_pkg::ADDR_PORT_CFG);

   // --------------------------------------------------------------------
   // Register access and steering
   // --------------------------------------------------------------------
   // Software reset wins over a write in the same cycle, since it restores
   // a known configuration that a stray write must not disturb.
   always_comb
   begin
      next_state = state;

      // Register file update.
      if (I_SW_RESET)
      begin
         next_state.port_configuration_register = ppc_pkg::PORT_CFG_RESET; // see R16
         next_state.port_configuration_register[ppc_pkg::BIT_SPEED_DOWNGRADE] =
            I_SPEED_DOWNGRADE_DEFAULT_BIT; // see R6
      end
      else if (I_WE && hit)
      begin
         // Reserved bits 6 and 9 are stored as written; software keeps them zero.
         next_state.port_configuration_register = I_WDATA & ppc_pkg::PORT_CFG_WMASK; // see R14
      end

      // Read path: unmapped addresses read as zero, data stand one cycle.
      if (I_RE && hit)
         next_state.rdata = cfg & ppc_pkg::PORT_CFG_WMASK; // see R14
      else
         next_state.rdata = 16'h0000;

      // Receive valid: with preamble pass it follows carrier sense at once,
      // otherwise it waits for the frame delimiter and holds to frame end.
      // A change of the preamble bit in mid-frame takes effect on the next edge.
      if (cfg[ppc_pkg::BIT_PREAMBLE_PASS])
      begin
         next_state.rx_dv = I_CRS; // see R4
         next_state.rx_preamble = I_CRS & ~I_SFD & ~(state.rx_dv & ~state.rx_preamble);
      end
      else
      begin
         next_state.rx_dv = I_CRS & (I_SFD | state.rx_dv); // see R3
         next_state.rx_preamble = 1'b0;
      end

      // Control outputs decoded from the stored fields.
      next_state.speed_downgrade_en = cfg[ppc_pkg::BIT_SPEED_DOWNGRADE]; // see R5
      next_state.loopback_suppress = cfg[ppc_pkg::BIT_LOOPBACK_SUPPRESS]
         & (I_SPEED == ppc_pkg::SPEED_10) & ~I_FULL_DUPLEX; // see R7
      next_state.jabber_disable = cfg[ppc_pkg::BIT_JABBER_DISABLE];
      next_state.bypass_4b5b = cfg[ppc_pkg::BIT_BYPASS_4B5B] & is_100; // see R8
      next_state.bypass_scrambler = cfg[ppc_pkg::BIT_BYPASS_SCRAMBLE] & is_100; // see R9
      next_state.tx_disable = cfg[ppc_pkg::BIT_TX_DISABLE]; // see R10
   end

   // Register the whole state; hardware reset leaves speed downgrade off.
   always_ff @(posedge I_CLOCK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         state <= '0;
         state.port_configuration_register <= ppc_pkg::PORT_CFG_RESET; // see R16
      end
      else
         state <= next_state;
   end

   // --------------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------------
   // The crossover timer length depends on the strict bit.
   // The timer and the link helper ignore software reset on purpose. A reset
   // of the register must not restart a pair-swap search or drop a link that
   // is already up.
   ppc_mdix_timer
   #(
      .STD_CYCLES(MDIX_STD_CYCLES),
      .LONG_CYCLES(MDIX_LONG_CYCLES),
      .CW(12)
   )
   u_mdix
   (
      .i_clock(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_strict(cfg[ppc_pkg::BIT_MDIX_STRICT]), // see R1
      .i_link_up(I_LINE_LINK),
      .o_swap(O_MDIX_SWAP)
   );

   // Force link pass acts differently per speed.
   always_comb
   begin
      link_in.speed = I_SPEED;
      link_in.force_link = cfg[ppc_pkg::BIT_FORCE_LINK]; // see R11
      link_in.line_link = I_LINE_LINK;
   end

   ppc_link_force u_link
   (
      .i_clock(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_link(link_in),
      .o_link(link_out)
   );

   // --------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------
   // Each output is a plain wire from a flip-flop of this core or of a helper,
   // so no decode sits between the registers and the pins.
   assign O_RDATA = state.rdata;
   assign O_RX_DV = state.rx_dv;
   assign O_RX_PREAMBLE = state.rx_preamble;
   assign O_SPEED_DOWNGRADE_EN = state.speed_downgrade_en;
   assign O_TP_LOOPBACK_SUPPRESS = state.loopback_suppress;
   assign O_JABBER_DISABLE = state.jabber_disable;
   assign O_BYPASS_4B5B = state.bypass_4b5b;
   assign O_BYPASS_SCRAMBLER = state.bypass_scrambler;
   assign O_TX_DISABLE = state.tx_disable;
   assign O_LINK_IND = link_out.link_ind;
   assign O_LINK_GOOD_STATE = link_out.link_good_state;
   assign O_AN_SKIP = link_out.an_skip;

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   // These checks watch the core's ports and its stored register. Each one is disabled
   // while hardware reset is low and judges outputs at the latency given
   // above: one cycle for read data and receive valid, two cycles from a
   // write strobe to a steered control output.

   // Reads return the stored value with the reserved top bit low.
   AST_RD_RESERVED: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R14
      (I_RE && hit) |=> (O_RDATA[15] == 1'b0 && O_RDATA == ($past(cfg) & 16'h7FF0)))
      else $error("Read data wrong or reserved bit set.");

   // Without preamble pass, carrier alone keeps receive valid low.
   AST_RXDV_SFD: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R3
      (!cfg[5] && !O_RX_DV && I_CRS && !I_SFD) |=> !O_RX_DV)
      else $error("Receive valid rose before the delimiter.");

   // With preamble pass, receive valid follows carrier sense one cycle later.
   AST_RXDV_PRE: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R4
      (cfg[5] && I_CRS) |=> O_RX_DV)
      else $error("Receive valid did not follow carrier sense.");

   // A write reaches the downgrade output two cycles after the strobe.
   AST_SPEED_WR: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R5
      (I_WE && hit && !I_SW_RESET) |=> ##1 (O_SPEED_DOWNGRADE_EN == $past(I_WDATA[7], 2)))
      else $error("Speed downgrade enable not taken from write.");

   // Software reset takes bit 7 from the nonvolatile default, not a constant.
   AST_SPEED_SWRST: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R6
      I_SW_RESET |=> (cfg[7] == $past(I_SPEED_DOWNGRADE_DEFAULT_BIT) && cfg[5] && cfg[8] && !cfg[14]))
      else $error("Software reset loaded wrong defaults.");

   // Loopback suppression applies only at 10M in half duplex.
   AST_LOOPBACK: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R7
      (cfg[8] && I_SPEED == 2'h0 && !I_FULL_DUPLEX) |=> O_TP_LOOPBACK_SUPPRESS)
      else $error("Loopback not suppressed in 10M half duplex.");

   // The coder bypass is gated by 100M, so it never leaks to other speeds.
   AST_BYPASS_CODER: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R8
      1'b1 |=> (O_BYPASS_4B5B == ($past(cfg[11]) && $past(I_SPEED) == 2'h1)))
      else $error("Coder bypass mismatch.");

   // The scrambler bypass is gated by 100M in the same way.
   AST_BYPASS_SCR: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R9
      1'b1 |=> (O_BYPASS_SCRAMBLER == ($past(cfg[12]) && $past(I_SPEED) == 2'h1)))
      else $error("Scrambler bypass mismatch.");

   // The transmitter disable follows a write with the same two-cycle latency.
   AST_TX_OFF: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R10
      (I_WE && hit && !I_SW_RESET) |=> ##1 (O_TX_DISABLE == $past(I_WDATA[13], 2)))
      else $error("Transmitter disable not taken from write.");

   // Only a write or a software reset may alter the stored register.
   AST_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see R16
      !(I_WE && hit) && !I_SW_RESET |=> $stable(cfg))
      else $error("Register changed without a write or reset.");

endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the port configuration register bank.
// Assumes the core drives registered outputs and answers reads one cycle late.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // Stimulus and model state
   // ----------------------------------------
   logic clk = 1'b0; // Bench clock, 40 MHz.
   logic rst_n = 1'b0; // Asynchronous reset, active low.
   logic sw_rst = 1'b0, def_bit = 1'b0, we = 1'b0, re = 1'b0, fd = 1'b0, line = 1'b1, crs = 1'b0, sfd = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic [1:0] speed = 2'h0;
   logic [15:0] rdata;
   logic rx_dv, rx_pre, sde, tls, jab, b4, bs, txd, swap, lind, lgood, anskip;
   int failures = 0; // Mismatches seen.
   int checks_done = 0; // Comparisons made.
   int cfg = 'h0120; // Model of the register, held as an integer.
   int expq[$]; // Expected read data, in issue order.
   int n;
   logic s0;
   // Small timer limits keep the crossover runs short.
   ppc_port_cfg #(.MDIX_STD_CYCLES(3), .MDIX_LONG_CYCLES(7)) uut (.I_CLOCK(clk), .I_ARST_N(rst_n),
      .I_SW_RESET(sw_rst), .I_SPEED_DOWNGRADE_DEFAULT_BIT(def_bit), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WE(we), .I_RE(re), .I_SPEED(speed), .I_FULL_DUPLEX(fd), .I_LINE_LINK(line), .I_CRS(crs),
      .I_SFD(sfd), .O_RDATA(rdata), .O_RX_DV(rx_dv), .O_RX_PREAMBLE(rx_pre), .O_SPEED_DOWNGRADE_EN(sde),
      .O_TP_LOOPBACK_SUPPRESS(tls), .O_JABBER_DISABLE(jab), .O_BYPASS_4B5B(b4), .O_BYPASS_SCRAMBLER(bs),
      .O_TX_DISABLE(txd), .O_MDIX_SWAP(swap), .O_LINK_IND(lind), .O_LINK_GOOD_STATE(lgood),
      .O_AN_SKIP(anskip));
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // One comparison; the expected value comes from the model.
   task automatic chk(input logic [15:0] got, input int exp, input string what);
      checks_done++;
      if (got !== 16'(exp))
      begin
         failures++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, 16'(exp));
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Single-cycle write; the model drops the bits that read as zero.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
      if (a == 5'h10)
         cfg = int'(d) & 'h7FF0;
   endtask
   // Single-cycle read; the data stand only in the following cycle.
   task automatic rd(input logic [4:0] a);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      expq.push_back((a == 5'h10) ? cfg : 0);
      @(posedge clk);
      re <= 1'b0;
      #1;
      chk(rdata, expq.pop_front(), "read data");
   endtask
   // Lets two edges pass so that steered outputs reflect the inputs.
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   // Compares the six control outputs decoded from the register with the model for the present speed.
   task automatic chk_ctl();
      chk({tls, jab, b4, bs, txd, sde}, {cfg[8] & (speed == 2'h0) & !fd, cfg[10], cfg[11] & (speed == 2'h1),
         cfg[12] & (speed == 2'h1), cfg[13], cfg[7]}, "control outputs");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(23));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(5'h10);
      // Random writes with reads back to back, and a stray address that must stay dead.
      repeat (12)
      begin
         wr(5'h10, 16'($urandom) & 16'h7DBF);
         rd(5'h10);
         wr(5'h11, 16'($urandom));
         rd(5'h11);
         rd(5'h10);
      end
      // Every speed and duplex against random settings.
      for (int sp = 0; sp < 4; sp++)
      begin
         for (int f = 0; f < 2; f++)
         begin
            wr(5'h10, (16'($urandom) & 16'h7DBF) | 16'h0100);
            @(posedge clk);
            speed <= 2'(sp);
            fd <= f[0];
            line <= 1'($urandom);
            settle();
            chk_ctl();
            // Link helper: forced link is shown at 10M and 100M, only skips negotiation at 1000M.
            chk({lind, lgood, anskip}, (sp >= 2) ? {line, line, cfg[14] == 1} : (sp == 1) ?
               {2{cfg[14] == 1 || line}} << 1 : {cfg[14] == 1 || line, line, 1'b0}, "link");
         end
      end
      // Software reset loads the nonvolatile default into the downgrade bit.
      for (int d = 0; d < 2; d++)
      begin
         wr(5'h10, 16'h7DB0);
         @(posedge clk);
         def_bit <= d[0];
         sw_rst <= 1'b1;
         @(posedge clk);
         sw_rst <= 1'b0;
         cfg = 'h0120 | (d << 7);
         rd(5'h10);
         settle();
         chk_ctl();
      end
      // Hardware reset in mid-run: the downgrade bit returns to zero.
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cfg = 'h0120;
      rd(5'h10);
      settle();
      chk_ctl();
      // Receive valid with preamble passing, then aligned to the delimiter.
      @(posedge clk);
      crs <= 1'b1;
      settle();
      chk({rx_dv, rx_pre}, 3, "valid with preamble");
      @(posedge clk);
      sfd <= 1'b1;
      settle();
      chk({rx_dv, rx_pre}, 2, "valid after preamble");
      @(posedge clk);
      crs <= 1'b0;
      sfd <= 1'b0;
      wr(5'h10, 16'h0000);
      settle();
      @(posedge clk);
      crs <= 1'b1;
      settle();
      chk(rx_dv, 0, "valid before delimiter");
      @(posedge clk);
      sfd <= 1'b1;
      settle();
      chk(rx_dv, 1, "valid at delimiter");
      @(posedge clk);
      crs <= 1'b0;
      sfd <= 1'b0;
      // Crossover timer: long first timeout with bit 4 clear, standard with it set.
      for (int st = 0; st < 2; st++)
      begin
         wr(5'h10, st ? 16'h0010 : 16'h0000);
         line <= 1'b1;
         settle();
         s0 = swap;
         @(posedge clk);
         line <= 1'b0;
         n = 0;
         while (swap === s0 && n < 40)
         begin
            @(posedge clk);
            #1;
            n++;
         end
         checks_done++;
         if (n < (st ? 3 : 7) || n > (st ? 6 : 10))
         begin
            failures++;
            $display("[FAIL] %0t crossover timeout after %0d cycles", $time, n);
         end
         @(posedge clk);
         line <= 1'b1;
      end
      summarize();
   end
endmodule
`default_nettype wire
